// *** include/ipc_defs.vh ***
// Constants of the interrupt priority, extended enable and external input block.
// Included by the ipc_arbiter and ipc_irq_ctrl design files; holds definitions only.
`ifndef IPC_DEFS_VH
`define IPC_DEFS_VH

// Special function register byte addresses.
`define IPC_ADDR_BASIC_PRIO 8'hB8
`define IPC_ADDR_EXT_CFG 8'hE4
`define IPC_ADDR_EXT_EN 8'hE6
`define IPC_ADDR_EXT_PRIO 8'hF6

// Reset values.
`define IPC_RST_BASIC_PRIO 8'hC0
`define IPC_RST_EXT_CFG 8'h01
`define IPC_RST_EXT_EN 8'h00
`define IPC_RST_EXT_PRIO 8'hC0
`define IPC_RST_PINS 8'hFF

// Implemented bits and the fixed value of the unused top bits.
`define IPC_IMPL_MASK 8'h3F
`define IPC_PRIO_UNUSED_READ 8'hC0
`define IPC_EN_UNUSED_READ 8'h00

// External input configuration fields.
`define IPC_IN1_POL_BIT 7
`define IPC_IN1_SEL_HI 6
`define IPC_IN1_SEL_LO 4
`define IPC_IN0_POL_BIT 3
`define IPC_IN0_SEL_HI 2
`define IPC_IN0_SEL_LO 0

// Bit-addressable window of the basic priority register.
`define IPC_BIT_ADDR_MASK 8'hF8
`define IPC_BIT_LAST_IMPL 3'h5

// Source numbers in fixed arbitration order, 0 wins ties.
`define IPC_SRC_EXT0 4'h0
`define IPC_SRC_EXT1 4'h2
`define IPC_SRC_COUNT 12

`endif

// *** rtl/ipc_ext_input.v ***
// External input channel: selects one port pin, applies polarity, keeps the pending flag.
// Expects the pin bus already synchronised to i_clk by its instantiator.
`timescale 1ns/10ps
module ipc_ext_input (
   input wire i_clk,
   input wire i_reset_n,
   input wire [7:0] i_pins_sync,
   input wire [2:0] i_pin_select,
   input wire i_polarity,
   input wire i_edge_mode,
   input wire i_vector_ack,
   input wire i_sw_clear,
   output reg o_pending
);

   reg active_d;
   wire pin_level;
   wire active;
   wire rise;

   // The pin is only observed, so whatever drives it is left undisturbed.
   assign pin_level = i_pins_sync[i_pin_select]; // R15 R16 R17
   assign active = i_polarity ? pin_level : ~pin_level; // R13 R14
   assign rise = active & ~active_d;

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         active_d <= 1'b0;
         o_pending <= 1'b0;
      end else begin
         active_d <= active;
         if (!i_edge_mode) begin
            o_pending <= active; // R21
         end else if (rise) begin
            o_pending <= 1'b1;
         end else if (i_vector_ack || i_sw_clear) begin
            o_pending <= 1'b0; // R21
         end
      end
   end

endmodule // ipc_ext_input

// *** rtl/ipc_arbiter.v ***
// Two-level fixed-order arbiter with preemption control.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "ipc_defs.vh"
module ipc_arbiter #(
   parameter N = `IPC_SRC_COUNT
) (
   input wire [N-1:0] i_requests,
   input wire [N-1:0] i_high_prio,
   input wire i_high_in_service,
   input wire i_low_in_service,
   output reg o_valid,
   output reg o_high,
   output reg [3:0] o_index
);

   wire [N-1:0] high_req;
   wire [N-1:0] low_req;

   assign high_req = i_requests & i_high_prio;
   assign low_req = i_requests & ~i_high_prio;

   function [3:0] first_set;
      input [N-1:0] vec;
      integer k;
      begin
         first_set = 4'h0;
         for (k = N - 1; k >= 0; k = k - 1) begin
            if (vec[k]) begin
               first_set = k[3:0];
            end
         end
      end
   endfunction

   // A high routine blocks everything; a low routine admits only high requests.
   always @* begin
      o_valid = 1'b0;
      o_high = 1'b0;
      o_index = 4'h0;
      if (!i_high_in_service) begin
         if (|high_req) begin
            o_valid = 1'b1; // R19
            o_high = 1'b1;
            o_index = first_set(high_req); // R19
         end else if (!i_low_in_service && (|low_req)) begin
            o_valid = 1'b1;
            o_index = first_set(low_req); // R19
         end
      end
   end

endmodule // ipc_arbiter

// *** rtl/ipc_irq_ctrl.v ***
// Interrupt priority, extended enable and external input configuration block.
// The CPU reaches the four registers over its special function register port,
// by byte and, for the basic priority register, by single bit. Peripheral
// pending flags arrive on the CPU clock; port pins arrive asynchronously.
`timescale 1ns/10ps
`include "ipc_defs.vh"

// Operation
// (R1) Basic priority bits 7-6 read as ones; writes to them are ignored.
// (R2) Basic priority bits 0-5: ext0, timer0, ext1, timer1, uart, timer2.
// (R3) Basic priority resets to C0, address B8, bit addressable.
// (R4) Extended enable bits 7-6 read zero, writes ignored.
// (R5) Extended enable bits 5 and 4 gate comparator rise and fall requests.
// (R6) Extended enable bit 3 gates every counter array request.
// (R7) Extended enable bits 2 and 1 gate ADC done and window requests.
// (R8) Extended enable bit 0 gates the two-wire serial request.
// (R9) Extended enable resets to 00 at address E6.
// (R10) Extended priority bits 7-6 read ones, writes ignored.
// (R11) Extended priority uses the extended enable bit order; one means high.
// (R12) Extended priority resets to C0 at address F6.
// (R13) Configuration bit 7 sets external input 1 polarity, one active high.
// (R14) Configuration bit 3 sets external input 0 polarity, one active high.
// (R15) Bits 6-4 pick the port 0 pin watched by external input 1.
// (R16) Bits 2-0 pick the port 0 pin watched by external input 0.
// (R17) Pins are only observed, independent of pin routing, never disturbed.
// (R18) Configuration resets to 01 at address E4.
// (R19) High preempts low, high is never preempted, ties use fixed order.
// (R20) Global enable low blocks every request including extended ones.
// (R21) Edge pending clears on vectoring; level pending follows the input.
// (R22) Request needs pending, enable and global enable; priority bit picks level.
module ipc_irq_ctrl (
   input wire i_clk,
   input wire i_reset_n,
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_wr,
   input wire i_sfr_rd,
   input wire [7:0] i_sfr_wdata,
   output reg [7:0] o_sfr_rdata,
   output reg o_sfr_hit,
   input wire [7:0] i_sfr_bit_addr,
   input wire i_sfr_bit_wr,
   input wire i_sfr_bit_rd,
   input wire i_sfr_bit_wdata,
   output reg o_sfr_bit_rdata,
   input wire i_global_irq_enable,
   input wire [5:0] i_basic_irq_en,
   input wire i_ext_in0_edge_mode,
   input wire i_ext_in1_edge_mode,
   input wire i_ext_in0_pending_clr,
   input wire i_ext_in1_pending_clr,
   input wire [7:0] i_port0_pins,
   input wire i_timer0_flag,
   input wire i_timer1_flag,
   input wire i_uart_flag,
   input wire i_timer2_flag,
   input wire i_twowire_flag,
   input wire i_adc_window_flag,
   input wire i_adc_done_flag,
   input wire i_counter_array_flag,
   input wire i_cmp_fall_flag,
   input wire i_cmp_rise_flag,
   input wire i_vector_ack,
   input wire i_reti,
   output reg o_irq_request,
   output reg o_irq_high,
   output reg [3:0] o_irq_source,
   output wire o_ext_in0_pending,
   output wire o_ext_in1_pending,
   output reg o_high_in_service,
   output reg o_low_in_service
);

   // Implemented bits only; the unused top bits are never stored.
   reg [5:0] basic_irq_priority;
   reg [5:0] extended_irq_enable;
   reg [5:0] extended_irq_priority;
   reg [7:0] ext_input_pin_polarity_cfg;

   reg [7:0] pins_meta;
   reg [7:0] pins_sync;

   // Reset values of the stored bits, with the unused top bits taken off.
   localparam [7:0] BASIC_PRIO_RST = `IPC_RST_BASIC_PRIO & `IPC_IMPL_MASK;
   localparam [7:0] EXT_EN_RST = `IPC_RST_EXT_EN & `IPC_IMPL_MASK;
   localparam [7:0] EXT_PRIO_RST = `IPC_RST_EXT_PRIO & `IPC_IMPL_MASK;

   wire timer0_high_prio;
   wire timer1_high_prio;
   wire timer2_high_prio;
   wire uart_high_prio;
   wire ext_in0_high_prio;
   wire ext_in1_high_prio;
   wire twowire_irq_en;
   wire adc_window_irq_en;
   wire adc_done_irq_en;
   wire counter_array_irq_en;
   wire cmp_fall_irq_en;
   wire cmp_rise_irq_en;
   wire ext_in1_polarity;
   wire ext_in0_polarity;
   wire [2:0] ext_in1_pin_select;
   wire [2:0] ext_in0_pin_select;

   wire [11:0] pending_vec;
   wire [11:0] enable_vec;
   wire [11:0] high_prio_vec;
   wire [11:0] gated_requests;
   wire arb_valid;
   wire arb_high;
   wire [3:0] arb_index;
   wire ack_ext0;
   wire ack_ext1;
   wire bit_hit;
   wire [2:0] bit_pos;
   wire [7:0] basic_view;

   // Named views of the register fields.
   assign timer2_high_prio = basic_irq_priority[5];
   assign uart_high_prio = basic_irq_priority[4];
   assign timer1_high_prio = basic_irq_priority[3];
   assign ext_in1_high_prio = basic_irq_priority[2];
   assign timer0_high_prio = basic_irq_priority[1];
   assign ext_in0_high_prio = basic_irq_priority[0];

   assign cmp_rise_irq_en = extended_irq_enable[5];
   assign cmp_fall_irq_en = extended_irq_enable[4];
   assign counter_array_irq_en = extended_irq_enable[3];
   assign adc_done_irq_en = extended_irq_enable[2];
   assign adc_window_irq_en = extended_irq_enable[1];
   assign twowire_irq_en = extended_irq_enable[0];

   assign ext_in1_polarity = ext_input_pin_polarity_cfg[`IPC_IN1_POL_BIT];
   assign ext_in0_polarity = ext_input_pin_polarity_cfg[`IPC_IN0_POL_BIT];
   assign ext_in1_pin_select = ext_input_pin_polarity_cfg[`IPC_IN1_SEL_HI:`IPC_IN1_SEL_LO];
   assign ext_in0_pin_select = ext_input_pin_polarity_cfg[`IPC_IN0_SEL_HI:`IPC_IN0_SEL_LO];

   // Byte view of a register, including the fixed value of its unused bits.
   function [7:0] sfr_view;
      input [7:0] addr;
      input [5:0] bprio;
      input [5:0] xen;
      input [5:0] xprio;
      input [7:0] cfg;
      begin
         case (addr)
            `IPC_ADDR_BASIC_PRIO: begin
               sfr_view = `IPC_PRIO_UNUSED_READ | {2'b00, bprio}; // R1
            end
            `IPC_ADDR_EXT_EN: begin
               sfr_view = `IPC_EN_UNUSED_READ | {2'b00, xen}; // R4
            end
            `IPC_ADDR_EXT_PRIO: begin
               sfr_view = `IPC_PRIO_UNUSED_READ | {2'b00, xprio}; // R10
            end
            `IPC_ADDR_EXT_CFG: begin
               sfr_view = cfg;
            end
            default: begin
               sfr_view = 8'h00;
            end
         endcase
      end
   endfunction

   function is_mapped;
      input [7:0] addr;
      begin
         is_mapped = (addr == `IPC_ADDR_BASIC_PRIO) || (addr == `IPC_ADDR_EXT_EN) ||
            (addr == `IPC_ADDR_EXT_PRIO) || (addr == `IPC_ADDR_EXT_CFG);
      end
   endfunction

   // Bit addresses B8..BF fall on the basic priority register.
   assign bit_hit = (i_sfr_bit_addr & `IPC_BIT_ADDR_MASK) == `IPC_ADDR_BASIC_PRIO; // R3
   assign bit_pos = i_sfr_bit_addr[2:0];

   // Byte view of the basic priority register, read back bit by bit.
   assign basic_view = sfr_view(`IPC_ADDR_BASIC_PRIO, basic_irq_priority, extended_irq_enable,
      extended_irq_priority, ext_input_pin_polarity_cfg);

   // Port pins come from outside the clock domain. Both stages reset to the level of an
   // idle, pulled-up pin, so no false edge or active level follows reset.
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pins_meta <= `IPC_RST_PINS;
         pins_sync <= `IPC_RST_PINS;
      end else begin
         pins_meta <= i_port0_pins;
         pins_sync <= pins_meta;
      end
   end

   // Register writes; byte writes and bit writes both reach the basic priority register.
   // A byte write in the same cycle as a bit write wins.
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         basic_irq_priority <= BASIC_PRIO_RST[5:0];
         extended_irq_enable <= EXT_EN_RST[5:0];
         extended_irq_priority <= EXT_PRIO_RST[5:0];
         ext_input_pin_polarity_cfg <= `IPC_RST_EXT_CFG;
      end else begin
         if (i_sfr_wr) begin
            case (i_sfr_addr)
               `IPC_ADDR_BASIC_PRIO: begin
                  basic_irq_priority <= i_sfr_wdata[5:0]; // R1 R2 R3
               end
               `IPC_ADDR_EXT_EN: begin
                  extended_irq_enable <= i_sfr_wdata[5:0]; // R4 R9
               end
               `IPC_ADDR_EXT_PRIO: begin
                  extended_irq_priority <= i_sfr_wdata[5:0]; // R10 R11 R12
               end
               `IPC_ADDR_EXT_CFG: begin
                  ext_input_pin_polarity_cfg <= i_sfr_wdata; // R18
               end
               default: begin
               end
            endcase
         end else if (i_sfr_bit_wr && bit_hit && (bit_pos <= `IPC_BIT_LAST_IMPL)) begin
            basic_irq_priority[bit_pos] <= i_sfr_bit_wdata; // R3
         end
      end
   end

   // Read answers are registered and appear one cycle after the strobe.
   // Bit reads share the byte view, so the unused bits read as ones there too.
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_sfr_rdata <= 8'h00;
         o_sfr_hit <= 1'b0;
         o_sfr_bit_rdata <= 1'b0;
      end else begin
         if (i_sfr_rd) begin
            o_sfr_rdata <= sfr_view(i_sfr_addr, basic_irq_priority, extended_irq_enable,
               extended_irq_priority, ext_input_pin_polarity_cfg);
            o_sfr_hit <= is_mapped(i_sfr_addr);
         end else begin
            o_sfr_hit <= 1'b0;
         end
         if (i_sfr_bit_rd) begin
            if (bit_hit) begin
               o_sfr_bit_rdata <= basic_view[bit_pos]; // R1
            end else begin
               o_sfr_bit_rdata <= 1'b0;
            end
         end
      end
   end

   // Vectoring clears an edge pending flag only when that input is the one being taken.
   assign ack_ext0 = i_vector_ack && o_irq_request && (o_irq_source == `IPC_SRC_EXT0);
   assign ack_ext1 = i_vector_ack && o_irq_request && (o_irq_source == `IPC_SRC_EXT1);

   ipc_ext_input u_ext_in0 (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_pins_sync(pins_sync),
      .i_pin_select(ext_in0_pin_select),
      .i_polarity(ext_in0_polarity),
      .i_edge_mode(i_ext_in0_edge_mode),
      .i_vector_ack(ack_ext0),
      .i_sw_clear(i_ext_in0_pending_clr),
      .o_pending(o_ext_in0_pending)
   );

   ipc_ext_input u_ext_in1 (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_pins_sync(pins_sync),
      .i_pin_select(ext_in1_pin_select),
      .i_polarity(ext_in1_polarity),
      .i_edge_mode(i_ext_in1_edge_mode),
      .i_vector_ack(ack_ext1),
      .i_sw_clear(i_ext_in1_pending_clr),
      .o_pending(o_ext_in1_pending)
   );

   // Source vectors in fixed arbitration order, bit 0 first.
   assign pending_vec = {i_cmp_rise_flag, i_cmp_fall_flag, i_counter_array_flag,
      i_adc_done_flag, i_adc_window_flag, i_twowire_flag, i_timer2_flag, i_uart_flag,
      i_timer1_flag, o_ext_in1_pending, i_timer0_flag, o_ext_in0_pending};
   assign enable_vec = {cmp_rise_irq_en, cmp_fall_irq_en, // R5
      counter_array_irq_en, // R6
      adc_done_irq_en, adc_window_irq_en, // R7
      twowire_irq_en, // R8
      i_basic_irq_en};
   assign high_prio_vec = {extended_irq_priority, // R11
      timer2_high_prio, uart_high_prio, timer1_high_prio, // R2
      ext_in1_high_prio, timer0_high_prio, ext_in0_high_prio}; // R2
   assign gated_requests = pending_vec & enable_vec & {12{i_global_irq_enable}}; // R20 R22

   // Requests are arbitrated afresh every cycle from the gated pending flags.
   ipc_arbiter #(
      .N(`IPC_SRC_COUNT)
   ) u_arbiter (
      .i_requests(gated_requests),
      .i_high_prio(high_prio_vec), // R22
      .i_high_in_service(o_high_in_service),
      .i_low_in_service(o_low_in_service),
      .o_valid(arb_valid),
      .o_high(arb_high),
      .o_index(arb_index)
   );

   // The request drops for the cycle after an acknowledge so a stale source is never offered.
   // Source and level are registered alongside the request, so the three always agree.
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_irq_request <= 1'b0;
         o_irq_high <= 1'b0;
         o_irq_source <= 4'h0;
      end else if (i_vector_ack) begin
         o_irq_request <= 1'b0;
      end else begin
         o_irq_request <= arb_valid; // R19 R22
         o_irq_high <= arb_high;
         o_irq_source <= arb_index;
      end
   end

   // In-service levels: a return ends the highest level that is active.
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_high_in_service <= 1'b0;
         o_low_in_service <= 1'b0;
      end else if (i_vector_ack && o_irq_request) begin
         if (o_irq_high) begin
            o_high_in_service <= 1'b1; // R19
         end else begin
            o_low_in_service <= 1'b1;
         end
      end else if (i_reti) begin
         if (o_high_in_service) begin
            o_high_in_service <= 1'b0;
         end else begin
            o_low_in_service <= 1'b0;
         end
      end
   end

endmodule // ipc_irq_ctrl

// *** verification/ipc_irq_ctrl_properties.sv ***
// Checker for the interrupt priority, enable and external input block.
// Bound to ipc_irq_ctrl; watches its ports only.
`timescale 1ns/10ps
module ipc_irq_ctrl_properties (
   input wire i_clk,
   input wire i_reset_n,
   input wire [7:0] i_sfr_addr,
   input wire i_sfr_wr,
   input wire i_sfr_rd,
   input wire [7:0] o_sfr_rdata,
   input wire o_sfr_hit,
   input wire [7:0] i_sfr_bit_addr,
   input wire i_sfr_bit_rd,
   input wire o_sfr_bit_rdata,
   input wire i_global_irq_enable,
   input wire i_vector_ack,
   input wire i_reti,
   input wire o_irq_request,
   input wire o_irq_high,
   input wire o_high_in_service,
   input wire o_low_in_service
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   wire rd_only = i_sfr_rd && !i_sfr_wr;
   wire mapped = (i_sfr_addr == 8'hB8) || (i_sfr_addr == 8'hE4) ||
      (i_sfr_addr == 8'hE6) || (i_sfr_addr == 8'hF6);
   unmapped_read_a: assert property (rd_only && !mapped
      |=> !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped read answered");
   mapped_hit_a: assert property (rd_only && mapped |=> o_sfr_hit)
      else $error("mapped read without hit");
   prio_top_ones_a: assert property (rd_only && i_sfr_addr[3:0] == 4'h8 && mapped
      |=> o_sfr_rdata[7:6] == 2'b11) else $error("priority top bits not ones");
   prio_top_ones2_a: assert property (rd_only && i_sfr_addr == 8'hF6
      |=> o_sfr_rdata[7:6] == 2'b11) else $error("extended priority top bits not ones");
   en_top_zero_a: assert property (rd_only && i_sfr_addr == 8'hE6
      |=> o_sfr_rdata[7:6] == 2'b00) else $error("enable top bits not zero");
   bit_top_ones_a: assert property (i_sfr_bit_rd && i_sfr_bit_addr[7:1] == 7'h5F
      |=> o_sfr_bit_rdata) else $error("unused priority bit read zero");
   global_block_a: assert property (!i_global_irq_enable |=> !o_irq_request)
      else $error("request with global enable low");
   ack_takes_a: assert property (i_vector_ack && o_irq_request
      |=> !o_irq_request && ($past(o_irq_high) ? o_high_in_service : o_low_in_service))
      else $error("acknowledge not taken");
   high_no_preempt_a: assert property (o_high_in_service |-> !o_irq_request)
      else $error("request during high service");
   low_only_high_a: assert property (o_low_in_service && o_irq_request |-> o_irq_high)
      else $error("low request during low service");
   reti_order_a: assert property (o_high_in_service && i_reti
      |=> !o_high_in_service && o_low_in_service == $past(o_low_in_service))
      else $error("return did not end high level first");
   cover property (i_vector_ack && o_irq_request);
   cover property (o_low_in_service && o_irq_request);
   cover property (o_sfr_hit);
endmodule // ipc_irq_ctrl_properties
bind ipc_irq_ctrl ipc_irq_ctrl_properties u_ipc_irq_ctrl_properties (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
   .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
   .i_sfr_bit_addr(i_sfr_bit_addr), .i_sfr_bit_rd(i_sfr_bit_rd),
   .o_sfr_bit_rdata(o_sfr_bit_rdata), .i_global_irq_enable(i_global_irq_enable),
   .i_vector_ack(i_vector_ack), .i_reti(i_reti), .o_irq_request(o_irq_request),
   .o_irq_high(o_irq_high), .o_high_in_service(o_high_in_service),
   .o_low_in_service(o_low_in_service)
);

// *** verification/ipc_cpu_model.sv ***
// CPU side model: drives the byte and bit register ports of the block.
// Assumes requests are taken on the rising edge of i_clk.
`timescale 1ns/10ps
module ipc_cpu_model (
   input wire i_clk,
   input wire [7:0] i_rdata,
   input wire i_brdata,
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata,
   output logic [7:0] o_baddr,
   output logic o_bwr,
   output logic o_brd,
   output logic o_bwd
);
   initial begin
      {o_addr, o_wr, o_rd, o_wdata} = 18'h00000;
      {o_baddr, o_bwr, o_brd, o_bwd} = 11'h000;
   end
   // Released address and data lines show the inverse of their last value.
   task automatic acc(input bit wr, input [7:0] a, input [7:0] d, output [7:0] q);
      @(posedge i_clk);
      #2;
      {o_addr, o_wdata, o_wr, o_rd} = {a, d, wr, !wr};
      @(posedge i_clk);
      #2;
      {o_addr, o_wdata, o_wr, o_rd} = {~a, ~d, 2'b00};
      q = i_rdata;
   endtask
   task automatic bacc(input bit wr, input [7:0] a, input d, output q);
      @(posedge i_clk);
      #2;
      {o_baddr, o_bwd, o_bwr, o_brd} = {a, d, wr, !wr};
      @(posedge i_clk);
      #2;
      {o_baddr, o_bwd, o_bwr, o_brd} = {~a, ~d, 2'b00};
      q = i_brdata;
   endtask
endmodule // ipc_cpu_model

// *** verification/ipc_irq_ctrl_tb.sv ***
// Self-checking bench for the interrupt priority, enable and external input block.
// Assumes the CPU model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module ipc_irq_ctrl_tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic glob = 1'b0;
   logic [5:0] ben = 6'h00;
   logic edge0 = 1'b0;
   logic [7:0] pins = 8'hFF;
   logic t0f = 1'b0;
   logic uf = 1'b0;
   logic [5:0] xf = 6'h00;
   logic ack = 1'b0;
   logic reti = 1'b0;
   logic [7:0] q;
   logic qb;
   wire [7:0] addr, wdata, rdata, baddr;
   wire wr, rd, hit, bwr, brd, bwd, brdata, req, high, p0, p1, his, lis;
   wire [3:0] src;
   int error_cnt = 0;
   int samples_checked = 0;
   int i;
   always #25 clk = ~clk;
   ipc_cpu_model u_ipc_cpu_model (.i_clk(clk), .i_rdata(rdata), .i_brdata(brdata),
      .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .o_baddr(baddr),
      .o_bwr(bwr), .o_brd(brd), .o_bwd(bwd));
   ipc_irq_ctrl u_ipc_irq_ctrl (.i_clk(clk), .i_reset_n(reset_n), .i_sfr_addr(addr),
      .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
      .o_sfr_hit(hit), .i_sfr_bit_addr(baddr), .i_sfr_bit_wr(bwr), .i_sfr_bit_rd(brd),
      .i_sfr_bit_wdata(bwd), .o_sfr_bit_rdata(brdata), .i_global_irq_enable(glob),
      .i_basic_irq_en(ben), .i_ext_in0_edge_mode(edge0), .i_ext_in1_edge_mode(1'b0),
      .i_ext_in0_pending_clr(1'b0), .i_ext_in1_pending_clr(1'b0), .i_port0_pins(pins),
      .i_timer0_flag(t0f), .i_timer1_flag(1'b0), .i_uart_flag(uf), .i_timer2_flag(1'b0),
      .i_twowire_flag(xf[0]), .i_adc_window_flag(xf[1]), .i_adc_done_flag(xf[2]),
      .i_counter_array_flag(xf[3]), .i_cmp_fall_flag(xf[4]), .i_cmp_rise_flag(xf[5]),
      .i_vector_ack(ack), .i_reti(reti), .o_irq_request(req), .o_irq_high(high),
      .o_irq_source(src), .o_ext_in0_pending(p0), .o_ext_in1_pending(p1),
      .o_high_in_service(his), .o_low_in_service(lis));
   task automatic check_val(input [7:0] got, input [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic sw(input [7:0] a, input [7:0] d);
      u_ipc_cpu_model.acc(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input [7:0] a, input [7:0] e);
      u_ipc_cpu_model.acc(1'b0, a, 8'h00, q);
      check_val(q, e);
   endtask
   task automatic bit_chk(input [7:0] a, input e);
      u_ipc_cpu_model.bacc(1'b0, a, 1'b0, qb);
      check_val({7'h00, qb}, {7'h00, e});
   endtask
   // A pulse of one cycle on acknowledge or return; callers step between pulses.
   task automatic pulse(input bit is_ack);
      if (is_ack) ack = 1'b1;
      else reti = 1'b1;
      step(1);
      {ack, reti} = 2'b00;
   endtask
   task automatic t_regs();
      rd_chk(8'hB8, 8'hC0);
      rd_chk(8'hE4, 8'h01);
      rd_chk(8'hE6, 8'h00);
      rd_chk(8'hF6, 8'hC0);
      sw(8'hB8, 8'h2A);
      rd_chk(8'hB8, 8'hEA);
      sw(8'hE6, 8'hFF);
      rd_chk(8'hE6, 8'h3F);
      sw(8'hF6, 8'h15);
      rd_chk(8'hF6, 8'hD5);
      sw(8'hE4, 8'hA5);
      rd_chk(8'hE4, 8'hA5);
      sw(8'h55, 8'hFF);
      rd_chk(8'h55, 8'h00);
      sw(8'hE6, 8'h00);
      sw(8'hE4, 8'h01);
      $display("registers done");
   endtask
   task automatic t_bits();
      sw(8'hB8, 8'h00);
      u_ipc_cpu_model.bacc(1'b1, 8'hBD, 1'b1, qb);
      u_ipc_cpu_model.bacc(1'b1, 8'hBE, 1'b0, qb);
      rd_chk(8'hB8, 8'hE0);
      bit_chk(8'hBD, 1'b1);
      bit_chk(8'hBE, 1'b1);
      bit_chk(8'hC0, 1'b0);
      $display("bit access done");
   endtask
   task automatic t_ext_gate();
      glob = 1'b1;
      for (i = 0; i < 6; i++) begin
         xf = 6'h01 << i;
         step(2);
         check_val({7'h00, req}, 8'h00);
         sw(8'hE6, 8'h01 << i);
         step(1);
         check_val({req, 2'b00, high, src}, 8'(8'h86 + i + (i % 2 == 0 ? 16 : 0)));
         glob = 1'b0;
         step(2);
         check_val({7'h00, req}, 8'h00);
         {glob, xf} = 7'h40;
         sw(8'hE6, 8'h00);
      end
      $display("extended gating done");
   endtask
   task automatic t_basic();
      sw(8'hB8, 8'h00);
      {ben, t0f, uf} = 8'h4B;
      step(2);
      check_val({req, 2'b00, high, src}, 8'h81);
      sw(8'hB8, 8'h10);
      step(1);
      check_val({req, 2'b00, high, src}, 8'h94);
      pulse(1'b1);
      check_val({5'h00, lis, his, req}, 8'h02);
      step(2);
      check_val({7'h00, req}, 8'h00);
      uf = 1'b0;
      pulse(1'b0);
      step(1);
      check_val({req, 2'b00, high, src}, 8'h81);
      pulse(1'b1);
      check_val({5'h00, lis, his, req}, 8'h04);
      uf = 1'b1;
      step(2);
      check_val({req, 2'b00, high, src}, 8'h94);
      t0f = 1'b0;
      pulse(1'b1);
      uf = 1'b0;
      step(1);
      check_val({5'h00, lis, his, req}, 8'h06);
      pulse(1'b0);
      check_val({5'h00, lis, his, req}, 8'h04);
      step(1);
      pulse(1'b0);
      check_val({5'h00, lis, his, req}, 8'h00);
      ben = 6'h00;
      $display("priority done");
   endtask
   task automatic t_pins();
      for (i = 0; i < 8; i++) begin
         sw(8'hE4, {1'b1, i[2:0], 1'b0, i[2:0]});
         pins = 8'h01 << i;
         step(5);
         check_val({6'h00, p1, p0}, 8'h02);
         pins = ~(8'h01 << i);
         step(5);
         check_val({6'h00, p1, p0}, 8'h01);
      end
      $display("pin select done");
   endtask
   task automatic t_edge();
      // Input 0 stays inactive across the switch to edge mode, so no level pending is left.
      pins = 8'h80;
      step(4);
      sw(8'hE4, 8'h08);
      {edge0, ben} = 7'h41;
      step(4);
      pins = 8'h01;
      for (i = 0; i < 8 && p0 !== 1'b1; i++) step(1);
      check_val({7'h00, p0}, 8'h01);
      if (i == 8) complete_run();
      step(1);
      check_val({req, 2'b00, high, src}, 8'h80);
      pulse(1'b1);
      step(1);
      check_val({7'h00, p0}, 8'h00);
      $display("edge clear done");
   endtask
   initial begin
      step(6);
      reset_n = 1'b1;
      t_regs();
      t_bits();
      t_ext_gate();
      t_basic();
      t_pins();
      t_edge();
      complete_run();
   end
   initial begin
      #1000000;
      error_cnt++;
      complete_run();
   end
endmodule // ipc_irq_ctrl_tb
